/* File: verilog/adc_port_pkg.sv */
package adc_port_pkg;

  typedef enum logic [1:0] {
    MODE_HOST = 2'b00,
    MODE_SELF = 2'b01,
    MODE_UART = 2'b11
  } mode_t;

  localparam int WORD_BITS     = 16;
  localparam int FILTER_CYCLES = 1024;
  localparam int READY_RISE    = 1020;
  localparam int POLL_FIRST    = 76;
  localparam int POLL_STEP     = 128;
  localparam int SCLK_DIV      = 4;
  localparam int FRAME_BITS    = 11;
  localparam int FRAME_COUNT   = 2;

  localparam logic DEV_READY_N_RST = 1'b1;
  localparam logic CS_N_RST        = 1'b1;

  localparam int MCLK_PERIOD_NS    = 32;
  localparam int SYS_PERIOD_NS     = 8;
  localparam int CS_SETUP_MCLK     = 4;
  localparam int CS_SETUP_EXTRA_NS = 160;
  localparam int CS_SETUP_CYC      =
    (CS_SETUP_MCLK * MCLK_PERIOD_NS + CS_SETUP_EXTRA_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int SCLK_HALF_NS      = 256;
  localparam int SCLK_HALF_CYC     = SCLK_HALF_NS / SYS_PERIOD_NS;

endpackage

/* File: verilog/adc_link_if.sv */
`timescale 1ns/10ps
interface adc_link_if (
  input logic masterClock
);
  logic [1:0] modeSel;
  logic       csN;
  logic       sclkHost;
  logic       sclkHostOe;
  logic       sclkDev;
  logic       sclkDevOe;
  logic       sdOut;
  logic       sdOe;
  logic       readyN;
  logic       sclkPin;
  logic       dataPin;

  // Floating data reads high like an idle uart line; a floating clock reads low
  assign sclkPin = sclkDevOe ? sclkDev : (sclkHostOe & sclkHost);
  assign dataPin = sdOe ? sdOut : 1'b1;

  modport device (
    input  masterClock,
    input  modeSel,
    input  csN,
    input  sclkPin,
    output sclkDev,
    output sclkDevOe,
    output sdOut,
    output sdOe,
    output readyN
  );

  modport host (
    input  sclkPin,
    input  dataPin,
    input  readyN,
    output modeSel,
    output csN,
    output sclkHost,
    output sclkHostOe
  );
endinterface

/* File: verilog/adc_port_device.sv */
`timescale 1ns/10ps
module adc_port_device
  import adc_port_pkg::*;
#(
  parameter int WORD_W = WORD_BITS
)(
  adc_link_if.device              link,
  input  wire logic               rst_n,
  input  wire logic [WORD_W-1:0]  resultWord,
  output logic                    resultTaken,
  output logic                    filterStart
);

  localparam int CNT_W = $clog2(FILTER_CYCLES);
  localparam int BIT_W = $clog2(WORD_W + 1);
  localparam int PH_W  = $clog2(SCLK_DIV);
  localparam int FR_W  = $clog2(FRAME_BITS + 1);

  typedef struct packed {
    logic [3:0]            sync1;
    logic [3:0]            sync2;
    logic                  sclkPrev;
    logic [CNT_W-1:0]      cnt;
    logic                  readyN;
    logic                  active;
    logic [WORD_W-1:0]     data;
    logic [BIT_W-1:0]      bitsLeft;
    logic [PH_W-1:0]       phase;
    logic                  sclkOut;
    logic [FRAME_BITS-1:0] frame;
    logic [FR_W-1:0]       frameBits;
    logic [1:0]            framesLeft;
    logic                  dataOut;
    logic                  taken;
    logic                  cycStart;
  } dev_state_t;

  dev_state_t q;
  dev_state_t n;

  logic  csLow;
  logic  sclkFall;
  logic  wrap;
  logic  poll;
  logic  blocked;
  mode_t mode;

  // Builds one uart frame: start bit low, byte lsb first, two stop bits high
  function automatic logic [FRAME_BITS-1:0] uartFrame(
    input logic [WORD_W-1:0] word,
    input logic              upper
  );
    logic [7:0] b;
    b = upper ? word[WORD_W-1 -: 8] : word[WORD_W-9 -: 8];
    return {2'b11, b, 1'b0};
  endfunction

  // Sync bit order: host clock, select, mode pair
  assign csLow    = ~q.sync2[2];
  assign mode     = mode_t'(q.sync2[1:0]);
  assign sclkFall = q.sclkPrev & ~q.sync2[3];
  assign wrap     = (q.cnt == CNT_W'(FILTER_CYCLES - 1));
  // Poll points all share one phase of the 128-clock step
  assign poll     = (mode == MODE_SELF) &&
                    ((q.cnt % CNT_W'(POLL_STEP)) == CNT_W'(POLL_FIRST - 1));
  // A pending second uart frame holds the old word while select stays low
  assign blocked  = q.active ||
                    ((mode == MODE_UART) && (q.framesLeft == 2'd1) && csLow);

  always_comb
  begin
    n          = q;
    n.sync1    = {link.sclkPin, link.csN, link.modeSel};
    n.sync2    = q.sync1;
    n.sclkPrev = q.sync2[3];
    n.cnt      = q.cnt + CNT_W'(1);
    n.taken    = 1'b0;
    n.cycStart = wrap;

    unique case (mode)
      MODE_SELF:
      begin
        if (q.active)
        begin
          n.phase   = q.phase + PH_W'(1);
          n.sclkOut = (n.phase >= PH_W'(SCLK_DIV / 2));
          if (q.phase == PH_W'(SCLK_DIV - 1))
          begin
            n.data     = {q.data[WORD_W-2:0], 1'b0};
            n.bitsLeft = q.bitsLeft - BIT_W'(1);
            if (q.bitsLeft == BIT_W'(1))
            begin
              n.active = 1'b0;
              n.readyN = 1'b1;
            end
            else if (!csLow)
            begin
              // Select is never latched, so the bit ends and both pins float
              n.active = 1'b0;
            end
          end
        end
        else if (poll && csLow && q.bitsLeft != '0)
        begin
          n.active  = 1'b1;
          n.phase   = '0;
          n.sclkOut = 1'b0;
        end
      end

      MODE_HOST:
      begin
        if (!q.active)
        begin
          if (csLow && !q.readyN && q.bitsLeft != '0)
          begin
            n.active = 1'b1;
          end
        end
        else if (!csLow)
        begin
          n.active = 1'b0;
        end
        else if (sclkFall)
        begin
          n.data     = {q.data[WORD_W-2:0], 1'b0};
          n.bitsLeft = q.bitsLeft - BIT_W'(1);
          if (q.bitsLeft == BIT_W'(1))
          begin
            n.active = 1'b0;
            n.readyN = 1'b1;
          end
        end
      end

      MODE_UART:
      begin
        if (sclkFall)
        begin
          if (q.active)
          begin
            n.frame     = {1'b1, q.frame[FRAME_BITS-1:1]};
            n.frameBits = q.frameBits - FR_W'(1);
            if (q.frameBits == FR_W'(1))
            begin
              n.framesLeft = q.framesLeft - 2'd1;
              if (q.framesLeft == 2'd1)
              begin
                n.active   = 1'b0;
                n.readyN   = 1'b1;
                n.bitsLeft = '0;
              end
              else if (csLow)
              begin
                // Held select runs the second frame back to back
                n.frame     = uartFrame(q.data, 1'b0);
                n.frameBits = FR_W'(FRAME_BITS);
              end
              else
              begin
                n.active = 1'b0;
              end
            end
          end
          else if (csLow && q.framesLeft != '0 && !wrap)
          begin
            // Start skipped on the reload edge so a frame never mixes two words
            n.active    = 1'b1;
            n.frame     = uartFrame(q.data, q.framesLeft == 2'(FRAME_COUNT));
            n.frameBits = FR_W'(FRAME_BITS);
          end
        end
      end

      default:
      begin
        n.active = 1'b0;
      end
    endcase

    // A transfer that starts on the rise edge keeps ready low, so outside uart mode ready never stands high over live data
    if (q.cnt == CNT_W'(READY_RISE - 1) && !blocked && !n.active)
    begin
      n.readyN = 1'b1;
    end

    if (wrap && !blocked)
    begin
      n.data       = resultWord;
      n.bitsLeft   = BIT_W'(WORD_W);
      n.framesLeft = 2'(FRAME_COUNT);
      n.readyN     = 1'b0;
      n.taken      = 1'b1;
    end

    n.dataOut = (mode == MODE_UART) ? n.frame[0] : n.data[WORD_W-1];
  end

  always_ff @(posedge link.masterClock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q          <= '0;
      q.readyN   <= DEV_READY_N_RST;
      q.sync1[2] <= CS_N_RST;
      q.sync2[2] <= CS_N_RST;
    end
    else
    begin
      q <= n;
    end
  end

  assign link.sdOut     = q.dataOut;
  assign link.sdOe      = q.active;
  assign link.sclkDev   = q.sclkOut;
  assign link.sclkDevOe = q.active && (mode == MODE_SELF);
  assign link.readyN    = q.readyN;
  assign resultTaken    = q.taken;
  assign filterStart    = q.cycStart;

endmodule // adc_port_device

/* File: verilog/adc_port_host.sv */
`timescale 1ns/10ps
module adc_port_host
  import adc_port_pkg::*;
#(
  parameter int WORD_W    = WORD_BITS,
  parameter int HALF_CYC  = SCLK_HALF_CYC,
  parameter int SETUP_CYC = CS_SETUP_CYC
)(
  adc_link_if.host                link,
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  input  wire mode_t              modeSel,
  input  wire logic               startReq,
  output logic                    busy,
  output logic [WORD_W-1:0]       wordOut,
  output logic                    wordValid,
  output logic                    resultReadyN
);

  localparam int SH_W = FRAME_BITS * FRAME_COUNT;
  localparam int BW   = $clog2(SH_W + 1);
  localparam int CW   = $clog2((HALF_CYC > SETUP_CYC ? HALF_CYC : SETUP_CYC) + 1);

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_WAIT = 2'b01,
    H_XFER = 2'b11,
    H_DONE = 2'b10
  } host_state_t;

  typedef struct packed {
    host_state_t       state;
    mode_t             mode;
    logic              csN;
    logic              sclkQ;
    logic [2:0]        sync1;
    logic [2:0]        sync2;
    logic              sclkPrev;
    logic [CW-1:0]     cnt;
    logic [BW-1:0]     bits;
    logic [SH_W-1:0]   shift;
    logic [WORD_W-1:0] word;
    logic              valid;
  } host_q_t;

  host_q_t q;
  host_q_t n;

  logic          selfMode;
  logic          uart;
  logic          tick;
  logic          sample;
  logic          dataS;
  logic [BW-1:0] total;

  // Sync bit order: ready, clock pin, data pin
  assign dataS    = q.sync2[0];
  assign selfMode = (q.mode == MODE_SELF);
  assign uart     = (q.mode == MODE_UART);
  assign tick     = (q.cnt == CW'(HALF_CYC - 1));
  assign total    = uart ? BW'(SH_W) : BW'(WORD_W);
  // Bits are taken on the rising clock edge, whoever makes the clock
  assign sample   = selfMode ? (~q.sclkPrev & q.sync2[1]) : (tick & ~q.sclkQ);

  always_comb
  begin
    n          = q;
    n.valid    = 1'b0;
    n.mode     = modeSel;
    n.sync1    = {link.readyN, link.sclkPin, link.dataPin};
    n.sync2    = q.sync1;
    n.sclkPrev = q.sync2[1];
    unique case (q.state)
      H_IDLE:
      begin
        if (startReq)
        begin
          n.csN   = 1'b0;
          n.cnt   = '0;
          n.bits  = '0;
          n.state = H_WAIT;
        end
      end
      H_WAIT:
      begin
        n.cnt = q.cnt + CW'(1);
        if (q.cnt == CW'(SETUP_CYC - 1))
        begin
          n.cnt   = '0;
          n.state = H_XFER;
        end
      end
      H_XFER, H_DONE:
      begin
        if (!selfMode)
        begin
          n.cnt = tick ? '0 : q.cnt + CW'(1);
          if (tick)
          begin
            n.sclkQ = ~q.sclkQ;
          end
        end
        if (q.state == H_XFER)
        begin
          // In uart mode the idle-high line is skipped until a start bit
          if (sample && !(uart && q.bits == '0 && dataS))
          begin
            n.shift = uart ? {dataS, q.shift[SH_W-1:1]} : {q.shift[SH_W-2:0], dataS};
            n.bits  = q.bits + BW'(1);
            if (q.bits == total - BW'(1))
            begin
              n.state = H_DONE;
            end
          end
        end
        else if (selfMode || (tick && !q.sclkQ))
        begin
          // With the host clock, select stays low half a period past the final fall
          n.csN   = 1'b1;
          n.sclkQ = 1'b0;
          n.cnt   = '0;
          n.valid = 1'b1;
          n.state = H_IDLE;
          n.word  = uart ? WORD_W'({q.shift[1 +: 8], q.shift[FRAME_BITS + 1 +: 8]})
                         : q.shift[WORD_W-1:0];
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q     <= '0;
      q.csN <= CS_N_RST;
    end
    else
    begin
      q <= n;
    end
  end

  assign link.modeSel    = q.mode;
  assign link.csN        = q.csN;
  assign link.sclkHost   = q.sclkQ;
  assign link.sclkHostOe = !selfMode;
  assign busy            = (q.state != H_IDLE);
  assign wordOut         = q.word;
  assign wordValid       = q.valid;
  assign resultReadyN    = q.sync2[2];

endmodule // adc_port_host

/* File: test/adc_serial_output_port_chk.sv */
`timescale 1ns/10ps
module adc_serial_output_port_chk (
  input wire logic       masterClock,
  input wire logic       rst_n,
  input wire logic [1:0] modeSel,
  input wire logic       csN,
  input wire logic       sclkPin,
  input wire logic       sclkDevOe,
  input wire logic       sdOut,
  input wire logic       sdOe,
  input wire logic       readyN
);
  logic [15:0] sinceFall_q;
  logic        fallSeen_q;
  logic        readyPrev_q;

  default clocking cb @(posedge masterClock);
  endclocking
  default disable iff (!rst_n);

  // Master clocks since ready fell; the first fall after reset has no reference yet
  always_ff @(posedge masterClock or negedge rst_n)
    if (!rst_n)
    begin
      sinceFall_q <= 16'h0;
      fallSeen_q  <= 1'b0;
      readyPrev_q <= 1'b1;
    end
    else
    begin
      readyPrev_q <= readyN;
      sinceFall_q <= (readyPrev_q && !readyN) ? 16'h1 : sinceFall_q + 16'h1;
      fallSeen_q  <= fallSeen_q | (readyPrev_q & ~readyN);
    end

  sequence s_clkHigh2;
    sclkPin [*2] ##1 !sclkPin;
  endsequence
  sequence s_clkLow2;
    !sclkPin [*2] ##1 sclkPin;
  endsequence
  sequence s_csSeen;
    modeSel == 2'b00 && $fell(csN) && !readyN ##1 (!csN && !readyN) [*3];
  endsequence

  a_load_period: assert property ($fell(readyN) && fallSeen_q |-> sinceFall_q[9:0] == 10'h0)
    else $error("Result load off the filter cycle grid");
  a_ready_rise: assert property ($rose(readyN) && !$past(sdOe) && fallSeen_q |-> sinceFall_q[9:0] == 10'h3fc)
    else $error("Idle ready rose at the wrong count");
  a_ready_pulse: assert property ($rose(readyN) && !$past(sdOe) && fallSeen_q |-> readyN [*4] ##1 !readyN)
    else $error("Idle ready high span is not four clocks");
  a_poll_slot: assert property ($rose(sdOe) && modeSel == 2'b01 && fallSeen_q |-> sinceFall_q[6:0] == 7'h4c)
    else $error("Self clocked transfer started off a poll point");
  a_self_high: assert property ($rose(sclkPin) && sclkDevOe |-> s_clkHigh2)
    else $error("Driven clock high phase is not two clocks");
  a_self_low: assert property ($fell(sclkPin) && sclkDevOe |-> s_clkLow2)
    else $error("Driven clock low phase is not two clocks");
  a_float_low: assert property ($fell(sclkDevOe) |-> $past(sclkPin) && !sdOe)
    else $error("Outputs did not float together at the end of a bit");
  a_host_answer: assert property (s_csSeen |=> sdOe)
    else $error("Select not answered with data drive");
  a_end_ready: assert property ($fell(sdOe) && modeSel != 2'b11 && !csN |-> readyN)
    else $error("Ready not raised when the word ended");
  a_hold_ready: assert property (modeSel == 2'b00 |-> !(sdOe && readyN))
    else $error("Ready high while bits are still being read");
  a_uart_start: assert property ($rose(sdOe) && modeSel == 2'b11 |-> !sdOut)
    else $error("Frame did not open with a low start bit");
  a_uart_stop: assert property ($fell(sdOe) && modeSel == 2'b11 |-> $past(sdOut))
    else $error("Frame did not close with a stop bit");
endmodule // adc_serial_output_port_chk

/* File: test/adc_serial_output_port_tb.sv */
`timescale 1ns/10ps
module adc_serial_output_port_tb;
  import adc_port_pkg::*;
  logic                 sys_clk;
  logic                 masterClock;
  logic                 rst_n;
  logic                 startReq;
  logic                 busy;
  logic                 wordValid;
  logic                 resultReadyN;
  logic                 resultTaken;
  logic                 filterStart;
  mode_t                modeSel;
  logic [WORD_BITS-1:0] resultWord;
  logic [WORD_BITS-1:0] wordOut;
  logic [WORD_BITS-1:0] lastLoaded;
  logic [WORD_BITS-1:0] expWord;
  int                   n_mismatch;
  int                   num_checks;

  adc_link_if adc_link_if_i (.masterClock(masterClock));
  adc_port_device adc_port_device_i (.link(adc_link_if_i), .rst_n(rst_n), .resultWord(resultWord),
    .resultTaken(resultTaken), .filterStart(filterStart));
  adc_port_host adc_port_host_i (.link(adc_link_if_i), .sys_clk(sys_clk), .rst_n(rst_n), .modeSel(modeSel),
    .startReq(startReq), .busy(busy), .wordOut(wordOut), .wordValid(wordValid), .resultReadyN(resultReadyN));
  adc_serial_output_port_chk chk_i (.masterClock(masterClock), .rst_n(rst_n), .modeSel(adc_link_if_i.modeSel),
    .csN(adc_link_if_i.csN), .sclkPin(adc_link_if_i.sclkPin), .sclkDevOe(adc_link_if_i.sclkDevOe),
    .sdOut(adc_link_if_i.sdOut), .sdOe(adc_link_if_i.sdOe), .readyN(adc_link_if_i.readyN));

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial
  begin
    masterClock = 1'b0;
    #3;
    forever #16 masterClock = ~masterClock;
  end

  // A new value after every load, so a stale or early reload shows as a wrong word
  always @(posedge masterClock)
    if (resultTaken === 1'b1)
    begin
      lastLoaded = resultWord;
      #1 resultWord = resultWord + 16'h9e37;
    end
  always @(posedge adc_link_if_i.sdOe)
    #2 expWord = lastLoaded;

  task automatic chkWord(input logic [WORD_BITS-1:0] got, input logic [WORD_BITS-1:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chkCount(input int got, input int exp, input string what);
    num_checks++;
    if (got != exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask

  task automatic countTo(input logic lvl, output int n);
    n = 0;
    do
    begin
      @(posedge masterClock);
      #1 n++;
    end
    while (adc_link_if_i.readyN !== lvl && n < 4000);
  endtask
  task automatic setMode(input mode_t m);
    @(posedge sys_clk);
    #1 modeSel = m;
    // The strap is registered on both sides before a transfer may use it
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic readWord(input string what);
    int t;
    // Start only after a fresh load; a word already read leaves nothing to send
    t = 0;
    while (resultReadyN !== 1'b1 && t < 5000)
    begin
      @(posedge sys_clk);
      #1 t++;
    end
    while (resultReadyN !== 1'b0 && t < 10000)
    begin
      @(posedge sys_clk);
      #1 t++;
    end
    @(posedge sys_clk);
    #1 startReq = 1'b1;
    @(posedge sys_clk);
    #1 startReq = 1'b0;
    chkCount(int'(busy === 1'b1), 1, {what, " busy"});
    t = 0;
    while (wordValid !== 1'b1 && t < 20000)
    begin
      @(posedge sys_clk);
      #1 t++;
    end
    chkCount(int'(wordValid === 1'b1), 1, {what, " completion"});
    chkCount(int'(busy === 1'b0), 1, {what, " idle again"});
    chkWord(wordOut, expWord, what);
  endtask

  task automatic testIdle;
    int n;
    countTo(1'b0, n);
    countTo(1'b1, n);
    chkCount(n, READY_RISE, "ready low span");
    countTo(1'b0, n);
    chkCount(n, FILTER_CYCLES - READY_RISE, "ready high span");
    chkCount(int'(filterStart === 1'b1), 1, "filter start on load");
    $display("test idle done");
  endtask
  task automatic testHost;
    setMode(MODE_HOST);
    readWord("host word");
    readWord("host word again");
    $display("test host done");
  endtask
  task automatic testSelf;
    setMode(MODE_SELF);
    readWord("self word");
    $display("test self done");
  endtask
  task automatic testUart;
    setMode(MODE_UART);
    readWord("uart word");
    $display("test uart done");
  endtask

  task automatic summarize;
    $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    rst_n = 1'b0;
    startReq = 1'b0;
    modeSel = MODE_HOST;
    resultWord = 16'ha5c3;
    lastLoaded = 16'h0;
    expWord = 16'h0;
    n_mismatch = 0;
    num_checks = 0;
    repeat (10) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    testIdle();
    testHost();
    testSelf();
    testUart();
    summarize();
  end
  initial
  begin
    #700000;
    n_mismatch++;
    summarize();
  end
endmodule // adc_serial_output_port_tb
